// [rts_pkg.sv]
// Constants, types and helpers for the reset time-out sequencer
package rts_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int POWER_UP_DELAY_TIMER_TIME_MS  = 72;
  localparam int POWER_UP_DELAY_TIMER_CYCLES   = POWER_UP_DELAY_TIMER_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int POWER_UP_DELAY_TIMER_CNT_W    = 23;
  localparam int OST_CYCLES    = 1024;
  localparam int OST_CNT_W     = 11;

  localparam logic [7:0] REG_STATUS   = 8'h00;
  localparam logic [7:0] REG_POWER_CONTROL_FLAGS     = 8'h04;
  localparam logic [7:0] REG_IRQ_ST   = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
  localparam logic [7:0] REG_SEQ      = 8'h10;

  localparam int ST_TO_BIT  = 4;
  localparam int ST_PD_BIT  = 3;
  localparam int PC_POR_BIT = 1;
  localparam int PC_BOR_BIT = 0;

  localparam logic [7:0]  STATUS_RESET = 8'h18;
  localparam logic [1:0]  POWER_CONTROL_FLAGS_RESET   = 2'h0;
  localparam logic [12:0] PC_RESET_VEC = 13'h0000;
  localparam logic [12:0] PC_IRQ_VEC   = 13'h0004;
  localparam logic [7:0]  OPTION_RESET = 8'hff;
  localparam logic [7:0]  TRIS_RESET   = 8'hff;
  localparam logic [7:0]  INTCON_RESET = 8'h00;

  localparam logic [1:0] OSC_LP = 2'h0;
  localparam logic [1:0] OSC_XT = 2'h1;
  localparam logic [1:0] OSC_HS = 2'h2;
  localparam logic [1:0] OSC_RC = 2'h3;

  localparam int IRQ_W = 7;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_RUN   = 3'b000,
    ST_SLEEP = 3'b001,
    ST_BOR   = 3'b010,
    ST_POWER_UP_DELAY_TIMER  = 3'b011,
    ST_OST   = 3'b100,
    ST_HOLD  = 3'b101
  } rts_state_t;

  typedef enum logic [3:0] {
    C_NONE       = 4'h0,
    C_POR        = 4'h1,
    C_BOR        = 4'h2,
    C_WDT_RST    = 4'h3,
    C_WDT_WAKE   = 4'h4,
    C_MASTER_CLEAR_PIN_RUN   = 4'h5,
    C_IRQ_WAKE   = 4'h6,
    C_MASTER_CLEAR_PIN_SLEEP = 4'h7,
    C_SLEEP      = 4'h8
  } rts_cause_t;

  // Clear bank bits, then set timeout/powerdown where enabled
  function automatic logic [7:0] rts_status_upd(input logic [7:0] cur, input logic clr_bank,
                                                input logic [1:0] tp, input logic [1:0] tp_en);
    logic [7:0] v;
    v = cur;
    if (clr_bank) begin
      v[7:5] = 3'b000;
    end
    if (tp_en[1]) begin
      v[ST_TO_BIT] = tp[1];
    end
    if (tp_en[0]) begin
      v[ST_PD_BIT] = tp[0];
    end
    return v;
  endfunction
endpackage

// [rts_tmr_if.sv]
// Run/done handshake between sequencer and its delay counters
`timescale 1ns/1ps
interface rts_tmr_if;
  logic run;
  logic done;
  modport ctrl (output run, input done);
  modport tmr  (input run, output done);
endinterface

// [rts_delay_timer.sv]
// Power-up delay timer on the free-running clock
`timescale 1ns/1ps
module rts_delay_timer import rts_pkg::*; #(
  parameter int TERM = POWER_UP_DELAY_TIMER_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  rts_tmr_if.tmr   t
);
  logic [POWER_UP_DELAY_TIMER_CNT_W-1:0] cnt_r;
  logic                  done_r;

  // Dropping run clears the count, so a restart is always full length
  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_r  <= '0;
      done_r <= 1'b0;
    end else if (clk_en) begin
      if (!t.run) begin
        cnt_r  <= '0;
        done_r <= 1'b0;
      end else if (cnt_r == POWER_UP_DELAY_TIMER_CNT_W'(TERM - 1)) begin
        done_r <= 1'b1;
      end else if (!done_r) begin
        cnt_r <= cnt_r + POWER_UP_DELAY_TIMER_CNT_W'(1);
      end
    end
  end

  assign t.done = done_r;
endmodule

// [rts_settle_counter.sv]
// Oscillator settle counter on rising edges of the oscillator input
`timescale 1ns/1ps
module rts_settle_counter import rts_pkg::*; (
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic osc_in,
  rts_tmr_if.tmr   t
);
  logic                 osc_prev_r;
  logic [OST_CNT_W-1:0] cnt_r;
  logic                 done_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      osc_prev_r <= 1'b0;
    end else if (clk_en) begin
      osc_prev_r <= osc_in;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_r  <= '0;
      done_r <= 1'b0;
    end else if (clk_en) begin
      if (!t.run) begin
        cnt_r  <= '0;
        done_r <= 1'b0;
      end else if (osc_in && !osc_prev_r && !done_r) begin
        if (cnt_r == OST_CNT_W'(OST_CYCLES - 1)) begin
          done_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r + OST_CNT_W'(1);
        end
      end
    end
  end

  assign t.done = done_r;
endmodule

// [rts_top.sv]
// Reset time-out sequencer with reset-cause flags and AXI4-Lite registers
`timescale 1ns/1ps
module rts_top import rts_pkg::*; #(
  parameter int POWER_UP_DELAY_TIMER_CYCLES_P = POWER_UP_DELAY_TIMER_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic        por_detect,
  input  wire logic        brownout_detect,
  input  wire logic        master_clear_pin_n,
  input  wire logic        oscillator_input_pin,
  input  wire logic        watchdog_timeout,
  input  wire logic        sleep_request,
  input  wire logic        irq_wake,
  input  wire logic        global_irq_enable,
  input  wire logic        brownout_enable_cfg,
  input  wire logic        power_up_delay_disable_cfg_n,
  input  wire logic [1:0]  osc_mode_cfg,
  output logic             core_reset,
  output logic             core_halt,
  output logic             sfr_reset,
  output logic             pc_load,
  output logic [12:0]      pc_value,
  output logic             pc_advance,
  output logic [7:0]       option_init,
  output logic [7:0]       tris_init,
  output logic [7:0]       intcon_init,
  output logic [7:0]       cpu_status,
  output logic             irq,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  rts_tmr_if power_up_delay_timer_if ();
  rts_tmr_if ost_if ();

  rts_state_t       state_r;
  rts_state_t       state_nxt;
  rts_cause_t       cause_nxt;
  logic             waking_r;
  logic             waking_nxt;
  logic             wake_irq_r;
  logic             resume_nxt;
  logic [7:0]       cpu_status_flags_r;
  logic [1:0]       power_control_flags_r;
  logic [IRQ_W-1:0] irq_st_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [IRQ_W-1:0] irq_ev;
  logic             bor_active;
  logic             power_up_delay_timer_needed;
  logic             osc_needed;
  logic             aw_hold_r;
  logic             w_hold_r;
  logic [7:0]       aw_addr_r;
  logic [31:0]      w_data_r;
  logic [3:0]       w_strb_r;
  logic             wr_fire;
  logic [31:0]      rd_val;
  logic             rd_err;
  logic             wr_err;

  assign bor_active  = brownout_enable_cfg && brownout_detect;
  assign power_up_delay_timer_needed = !power_up_delay_disable_cfg_n || brownout_enable_cfg;
  assign osc_needed  = osc_mode_cfg != OSC_RC;

  // First stage of a reset time-out: power-up delay, settle count or plain hold
  function automatic rts_state_t first_stage(input logic pw, input logic os);
    if (pw) begin
      return ST_POWER_UP_DELAY_TIMER;
    end else if (os) begin
      return ST_OST;
    end
    return ST_HOLD;
  endfunction

  rts_delay_timer #(
    .TERM (POWER_UP_DELAY_TIMER_CYCLES_P)
  ) u_power_up_delay_timer (
    .clock  (clock),
    .rst    (rst),
    .clk_en (clk_en),
    .t      (power_up_delay_timer_if.tmr)
  );

  rts_settle_counter u_ost (
    .clock  (clock),
    .rst    (rst),
    .clk_en (clk_en),
    .osc_in (oscillator_input_pin),
    .t      (ost_if.tmr)
  );

  assign power_up_delay_timer_if.run = state_r == ST_POWER_UP_DELAY_TIMER;
  assign ost_if.run  = state_r == ST_OST;

  // Sequencer; master clear pin is only ever sampled here
  always_comb begin
    state_nxt  = state_r;
    cause_nxt  = C_NONE;
    waking_nxt = waking_r;
    resume_nxt = 1'b0;
    if (por_detect) begin
      state_nxt  = first_stage(power_up_delay_timer_needed, osc_needed);
      cause_nxt  = C_POR;
      waking_nxt = 1'b0;
    end else if (bor_active) begin
      if (state_r != ST_BOR) begin
        cause_nxt = C_BOR;
      end
      state_nxt  = ST_BOR;
      waking_nxt = 1'b0;
    end else begin
      case (state_r)
        ST_RUN: begin
          if (!master_clear_pin_n) begin
            state_nxt = ST_HOLD;
            cause_nxt = C_MASTER_CLEAR_PIN_RUN;
          end else if (watchdog_timeout) begin
            state_nxt = ST_HOLD;
            cause_nxt = C_WDT_RST;
          end else if (sleep_request) begin
            state_nxt = ST_SLEEP;
            cause_nxt = C_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (!master_clear_pin_n) begin
            state_nxt = ST_HOLD;
            cause_nxt = C_MASTER_CLEAR_PIN_SLEEP;
          end else if (watchdog_timeout || irq_wake) begin
            cause_nxt = watchdog_timeout ? C_WDT_WAKE : C_IRQ_WAKE;
            if (osc_needed) begin
              state_nxt  = ST_OST;
              waking_nxt = 1'b1;
            end else begin
              state_nxt  = ST_RUN;
              resume_nxt = 1'b1;
            end
          end
        end
        ST_BOR: begin
          state_nxt = ST_POWER_UP_DELAY_TIMER;
        end
        ST_POWER_UP_DELAY_TIMER: begin
          if (power_up_delay_timer_if.done) begin
            state_nxt = osc_needed ? ST_OST : ST_HOLD;
          end
        end
        ST_OST: begin
          if (waking_r && !master_clear_pin_n) begin
            state_nxt  = ST_HOLD;
            cause_nxt  = C_MASTER_CLEAR_PIN_SLEEP;
            waking_nxt = 1'b0;
          end else if (ost_if.done) begin
            state_nxt  = waking_r ? ST_RUN : ST_HOLD;
            resume_nxt = waking_r;
            waking_nxt = 1'b0;
          end
        end
        ST_HOLD: begin
          if (master_clear_pin_n) begin
            state_nxt = ST_RUN;
          end
        end
        default: begin
          state_nxt  = ST_HOLD;
          waking_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_r    <= ST_HOLD;
      waking_r   <= 1'b0;
      wake_irq_r <= 1'b0;
      core_reset <= 1'b1;
      core_halt  <= 1'b0;
    end else if (clk_en) begin
      state_r  <= state_nxt;
      waking_r <= waking_nxt;
      if (cause_nxt == C_IRQ_WAKE || cause_nxt == C_WDT_WAKE) begin
        wake_irq_r <= cause_nxt == C_IRQ_WAKE;
      end
      core_reset <= !(state_nxt == ST_RUN || state_nxt == ST_SLEEP || waking_nxt);
      core_halt  <= state_nxt == ST_SLEEP || waking_nxt;
    end
  end

  // Program counter and special register loads
  always_ff @(posedge clock) begin
    if (rst) begin
      sfr_reset   <= 1'b1;
      pc_load     <= 1'b1;
      pc_value    <= PC_RESET_VEC;
      pc_advance  <= 1'b0;
      option_init <= OPTION_RESET;
      tris_init   <= TRIS_RESET;
      intcon_init <= INTCON_RESET;
    end else if (clk_en) begin
      sfr_reset  <= 1'b0;
      pc_load    <= 1'b0;
      pc_advance <= 1'b0;
      if (cause_nxt == C_POR || cause_nxt == C_BOR || cause_nxt == C_MASTER_CLEAR_PIN_RUN
          || cause_nxt == C_MASTER_CLEAR_PIN_SLEEP || cause_nxt == C_WDT_RST) begin
        sfr_reset   <= 1'b1;
        option_init <= OPTION_RESET;
        tris_init   <= TRIS_RESET;
        intcon_init <= INTCON_RESET;
        pc_load     <= 1'b1;
        pc_value    <= PC_RESET_VEC;
      end else if (resume_nxt) begin
        if (wake_irq_r_eff(cause_nxt, wake_irq_r) && global_irq_enable) begin
          pc_load  <= 1'b1;
          pc_value <= PC_IRQ_VEC;
        end else begin
          pc_advance <= 1'b1;
        end
      end
    end
  end

  // Wake kind: taken from this cycle's cause on a direct wake, else the stored one
  function automatic logic wake_irq_r_eff(input rts_cause_t c, input logic stored);
    if (c == C_IRQ_WAKE) begin
      return 1'b1;
    end else if (c == C_WDT_WAKE) begin
      return 1'b0;
    end
    return stored;
  endfunction

  // Core status flags; hardware updates take priority over software writes
  always_ff @(posedge clock) begin
    if (rst) begin
      cpu_status_flags_r <= STATUS_RESET;
    end else if (clk_en) begin
      case (cause_nxt)
        C_POR:        cpu_status_flags_r <= rts_status_upd(cpu_status_flags_r, 1'b1, 2'b11, 2'b11);
        C_BOR:        cpu_status_flags_r <= rts_status_upd(cpu_status_flags_r, 1'b1, 2'b11, 2'b11);
        C_MASTER_CLEAR_PIN_RUN:   cpu_status_flags_r <= rts_status_upd(cpu_status_flags_r, 1'b1, 2'b00, 2'b00);
        C_MASTER_CLEAR_PIN_SLEEP: cpu_status_flags_r <= rts_status_upd(cpu_status_flags_r, 1'b1, 2'b10, 2'b11);
        C_WDT_RST:    cpu_status_flags_r <= rts_status_upd(cpu_status_flags_r, 1'b1, 2'b01, 2'b11);
        C_WDT_WAKE:   cpu_status_flags_r <= rts_status_upd(cpu_status_flags_r, 1'b0, 2'b00, 2'b11);
        C_IRQ_WAKE:   cpu_status_flags_r <= rts_status_upd(cpu_status_flags_r, 1'b0, 2'b10, 2'b11);
        C_SLEEP:      cpu_status_flags_r <= rts_status_upd(cpu_status_flags_r, 1'b0, 2'b10, 2'b11);
        default: begin
          if (wr_fire && aw_addr_r == REG_STATUS && w_strb_r[0]) begin
            cpu_status_flags_r[7:5] <= w_data_r[7:5];
            cpu_status_flags_r[2:0] <= w_data_r[2:0];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cpu_status <= STATUS_RESET;
    end else if (clk_en) begin
      cpu_status <= cpu_status_flags_r;
    end
  end

  // Power control flags; software sets them, hardware clears win
  always_ff @(posedge clock) begin
    if (rst) begin
      power_control_flags_r <= POWER_CONTROL_FLAGS_RESET;
    end else if (clk_en) begin
      if (wr_fire && aw_addr_r == REG_POWER_CONTROL_FLAGS && w_strb_r[0]) begin
        power_control_flags_r <= w_data_r[1:0];
      end
      if (cause_nxt == C_POR) begin
        power_control_flags_r[PC_POR_BIT] <= 1'b0;
      end
      if (cause_nxt == C_BOR) begin
        power_control_flags_r[PC_BOR_BIT] <= 1'b0;
      end
    end
  end

  // Sticky event bits: 0 por, 1 bor, 2 wdt reset, 3 wdt wake, 4 master_clear_pin, 5 irq wake, 6 release
  assign irq_ev = {state_r != ST_RUN && state_nxt == ST_RUN,
                   cause_nxt == C_IRQ_WAKE,
                   cause_nxt == C_MASTER_CLEAR_PIN_RUN || cause_nxt == C_MASTER_CLEAR_PIN_SLEEP,
                   cause_nxt == C_WDT_WAKE,
                   cause_nxt == C_WDT_RST,
                   cause_nxt == C_BOR,
                   cause_nxt == C_POR};

  always_ff @(posedge clock) begin
    if (rst) begin
      irq_st_r   <= '0;
      irq_mask_r <= '0;
      irq        <= 1'b0;
    end else if (clk_en) begin
      if (wr_fire && aw_addr_r == REG_IRQ_ST && w_strb_r[0]) begin
        irq_st_r <= (irq_st_r & ~w_data_r[IRQ_W-1:0]) | irq_ev;
      end else begin
        irq_st_r <= irq_st_r | irq_ev;
      end
      if (wr_fire && aw_addr_r == REG_IRQ_MASK && w_strb_r[0]) begin
        irq_mask_r <= w_data_r[IRQ_W-1:0];
      end
      irq <= |(irq_st_r & irq_mask_r);
    end
  end

  // AXI4-Lite write: address and data taken in either order
  assign wr_fire = aw_hold_r && w_hold_r && !s_axi_bvalid;
  assign wr_err  = !(aw_addr_r == REG_STATUS || aw_addr_r == REG_POWER_CONTROL_FLAGS
                     || aw_addr_r == REG_IRQ_ST || aw_addr_r == REG_IRQ_MASK);

  always_ff @(posedge clock) begin
    if (rst) begin
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      aw_addr_r     <= '0;
      w_data_r      <= '0;
      w_strb_r      <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r     <= 1'b1;
        aw_addr_r     <= {s_axi_awaddr[7:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r     <= 1'b1;
        w_data_r     <= s_axi_wdata;
        w_strb_r     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_hold_r     <= 1'b0;
        w_hold_r      <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // AXI4-Lite read decode
  always_comb begin
    rd_val = '0;
    rd_err = 1'b0;
    if ({s_axi_araddr[7:2], 2'b00} == REG_STATUS) begin
      rd_val[7:0] = cpu_status_flags_r;
    end else if ({s_axi_araddr[7:2], 2'b00} == REG_POWER_CONTROL_FLAGS) begin
      rd_val[1:0] = power_control_flags_r;
    end else if ({s_axi_araddr[7:2], 2'b00} == REG_IRQ_ST) begin
      rd_val[IRQ_W-1:0] = irq_st_r;
    end else if ({s_axi_araddr[7:2], 2'b00} == REG_IRQ_MASK) begin
      rd_val[IRQ_W-1:0] = irq_mask_r;
    end else if ({s_axi_araddr[7:2], 2'b00} == REG_SEQ) begin
      rd_val[4:0] = {core_reset, waking_r, state_r};
    end else begin
      rd_err = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_val;
        s_axi_rresp   <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

// [rts_props.sv]
// Port checker for the reset time-out sequencer
`timescale 1ns/1ps
module rts_props import rts_pkg::*; #(
  parameter int POWER_UP_DELAY_TIMER_CYCLES_P = POWER_UP_DELAY_TIMER_CYCLES
) (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        por_detect,
  input wire logic        brownout_detect,
  input wire logic        master_clear_pin_n,
  input wire logic        watchdog_timeout,
  input wire logic        sleep_request,
  input wire logic        brownout_enable_cfg,
  input wire logic        power_up_delay_disable_cfg_n,
  input wire logic [1:0]  osc_mode_cfg,
  input wire logic        core_reset,
  input wire logic        core_halt,
  input wire logic        sfr_reset,
  input wire logic        pc_load,
  input wire logic [12:0] pc_value,
  input wire logic        pc_advance,
  input wire logic [7:0]  option_init,
  input wire logic [7:0]  tris_init,
  input wire logic [7:0]  intcon_init,
  input wire logic [7:0]  cpu_status
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_por_hold;
    por_detect && (!power_up_delay_disable_cfg_n || brownout_enable_cfg) |-> ##2 core_reset [*8];
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("reset dropped in delay");
  property p_bor_hold;
    (brownout_enable_cfg && brownout_detect) [*3] |-> core_reset;
  endproperty
  a_bor_hold: assert property (p_bor_hold) else $error("reset low in brown-out");
  property p_bor_restart;
    brownout_enable_cfg && $fell(brownout_detect) |-> core_reset [*8] ##1 core_reset [*8];
  endproperty
  a_bor_restart: assert property (p_bor_restart) else $error("short delay after brown-out");
  property p_bor_off;
    !brownout_enable_cfg && brownout_detect && !core_reset && master_clear_pin_n && !por_detect
      && !watchdog_timeout |=> !core_reset;
  endproperty
  a_bor_off: assert property (p_bor_off) else $error("disabled brown-out reset");
  property p_rc_nodly;
    por_detect && osc_mode_cfg == OSC_RC && power_up_delay_disable_cfg_n && !brownout_enable_cfg
      && master_clear_pin_n ##1 !por_detect |-> ##[1:4] !core_reset;
  endproperty
  a_rc_nodly: assert property (p_rc_nodly) else $error("delay in plain mode");
  property p_sfr;
    sfr_reset |-> pc_load && pc_value == PC_RESET_VEC && option_init == OPTION_RESET
      && tris_init == TRIS_RESET && intcon_init == INTCON_RESET;
  endproperty
  a_sfr: assert property (p_sfr) else $error("bad reset values");
  property p_por_status;
    por_detect ##1 !por_detect |-> ##[1:4] cpu_status[7:3] == 5'h03;
  endproperty
  a_por_status: assert property (p_por_status) else $error("bad status on power-on");
  property p_sleep;
    sleep_request && !core_reset && !core_halt && master_clear_pin_n && !watchdog_timeout
      |-> ##1 core_halt ##1 cpu_status[4:3] == 2'h2;
  endproperty
  a_sleep: assert property (p_sleep) else $error("bad sleep entry");
  property p_master_clear_pin;
    !master_clear_pin_n [*3] |-> core_reset;
  endproperty
  a_master_clear_pin: assert property (p_master_clear_pin) else $error("master clear ignored");
endmodule
bind rts_top rts_props #(.POWER_UP_DELAY_TIMER_CYCLES_P(POWER_UP_DELAY_TIMER_CYCLES_P)) props_u (.*);

// [rts_core_model.sv]
// Core model: oscillator source and program counter
`timescale 1ns/1ps
module rts_core_model (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        core_reset,
  input wire logic        core_halt,
  input wire logic        pc_load,
  input wire logic [12:0] pc_value,
  input wire logic        pc_advance,
  output logic            oscillator_input_pin,
  output logic [12:0]     core_pc
);
  always_ff @(posedge clock) begin
    oscillator_input_pin <= rst ? 1'b0 : ~oscillator_input_pin;
    if (pc_load) begin
      core_pc <= pc_value;
    end else if ((!core_reset && !core_halt) || pc_advance) begin
      core_pc <= core_pc + 13'h1;
    end
  end
endmodule

// [rts_top_tb.sv]
// Testbench for the reset time-out sequencer
`timescale 1ns/1ps
module rts_top_tb import rts_pkg::*;;
  localparam int P = 20;
  logic clock = 0, rst = 1, clk_en = 1, por_detect = 0, brownout_detect = 0, master_clear_pin_n = 1;
  logic watchdog_timeout = 0, sleep_request = 0, irq_wake = 0, global_irq_enable = 0, brownout_enable_cfg = 0;
  logic power_up_delay_disable_cfg_n = 0, oscillator_input_pin, core_reset, core_halt, sfr_reset, pc_load;
  logic pc_advance, irq, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [1:0] osc_mode_cfg = OSC_XT, s_axi_bresp, s_axi_rresp, rsp;
  logic [12:0] pc_value, core_pc;
  logic [7:0] option_init, tris_init, intcon_init, cpu_status, s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd_v;
  logic [3:0] s_axi_wstrb = 4'hf;
  int n_errors = 0, comparisons = 0, n, lo;
  rts_top #(.POWER_UP_DELAY_TIMER_CYCLES_P(P)) dut_u (.*);
  rts_core_model core_u (.*);
  always #5 clock = ~clock;
  task end_of_test;
    $display("TB: errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task tmo;
    chk("wait", 0, 1);
    end_of_test;
  endtask
  task cyc(input int k);
    repeat (k) @(posedge clock);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (i = 0; i < 50; i++) begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) break;
    end
    if (i == 50) tmo;
    rsp = s_axi_bresp;
  endtask
  task rd(input logic [7:0] a);
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (i = 0; i < 50; i++) begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) break;
    end
    if (i == 50) tmo;
    rd_v = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask
  task waitlow(input bit h);
    for (n = 0; n < 30000; n++) begin
      @(posedge clock);
      if ((h ? core_halt : core_reset) === 1'b0) break;
    end
    if (n == 30000) tmo;
  endtask
  task por_run(input logic [1:0] m, input logic dn);
    osc_mode_cfg <= m;
    power_up_delay_disable_cfg_n <= dn;
    cyc(1);
    por_detect <= 1;
    cyc(1);
    por_detect <= 0;
  endtask
  task pulse_wdt;
    watchdog_timeout <= 1;
    cyc(1);
    watchdog_timeout <= 0;
  endtask
  initial begin
    cyc(4);
    rst <= 0;
    cyc(1);
    rd(REG_STATUS); chk("status reset", 32'h18, rd_v);
    wr(REG_STATUS, 32'he5);
    wr(REG_POWER_CONTROL_FLAGS, 32'h3);
    master_clear_pin_n <= 0;
    por_run(OSC_XT, 0);
    cyc(P + 2300);
    chk("held", 1, core_reset);
    master_clear_pin_n <= 1;
    waitlow(0); chk("quick release", 1, n < 3);
    rd(REG_STATUS); chk("status por", 32'h1d, rd_v);
    rd(REG_POWER_CONTROL_FLAGS); chk("power_control_flags por", 32'h1, rd_v);
    for (int k = 0; k < 8; k++) begin
      por_run(k[1:0], k[2]);
      waitlow(0);
      lo = (k[2] ? 0 : P) + (k[1:0] == OSC_RC ? 0 : 2048);
      chk("release time", 1, n + 3 >= lo && n <= lo + 10);
    end
    wr(REG_POWER_CONTROL_FLAGS, 32'h3);
    brownout_enable_cfg <= 1;
    brownout_detect <= 1;
    cyc(5);
    brownout_detect <= 0;
    cyc(8);
    brownout_detect <= 1;
    cyc(3);
    brownout_detect <= 0;
    waitlow(0); chk("bor release", 1, n + 3 >= P && n <= P + 10);
    rd(REG_POWER_CONTROL_FLAGS); chk("power_control_flags bor", 32'h2, rd_v);
    rd(REG_STATUS); chk("status bor", 32'h3, rd_v[7:3]);
    brownout_enable_cfg <= 0;
    cyc(1);
    brownout_detect <= 1;
    cyc(6);
    chk("bor off", 0, core_reset);
    brownout_detect <= 0;
    pulse_wdt;
    waitlow(0); chk("pc reset", 1, core_pc <= 13'h2);
    rd(REG_STATUS); chk("status wdt", 32'h1, rd_v[4:3]);
    sleep_request <= 1;
    cyc(1);
    sleep_request <= 0;
    pulse_wdt;
    waitlow(1); chk("rc wake", 1, n < 4);
    rd(REG_STATUS); chk("status wake", 32'h0, rd_v[4:3]);
    osc_mode_cfg <= OSC_XT;
    global_irq_enable <= 1;
    sleep_request <= 1;
    cyc(1);
    sleep_request <= 0;
    irq_wake <= 1;
    cyc(1);
    irq_wake <= 0;
    waitlow(1); chk("xt wake", 1, n > 2040 && n < 2060);
    cyc(1); chk("pc vector", 1, core_pc >= 13'h4 && core_pc < 13'h8);
    wr(REG_IRQ_MASK, 32'h20);
    cyc(3); chk("irq on", 1, irq);
    wr(REG_IRQ_MASK, 32'h0);
    cyc(3); chk("irq masked", 0, irq);
    wr(REG_IRQ_MASK, 32'h20);
    wr(REG_IRQ_ST, 32'h20);
    cyc(3); chk("irq cleared", 0, irq);
    rd(8'h20); chk("unmapped rd", RESP_SLVERR, rsp);
    wr(8'h20, 32'h0); chk("unmapped wr", RESP_SLVERR, rsp);
    wr(REG_STATUS, 32'he0);
    master_clear_pin_n <= 0;
    cyc(3);
    master_clear_pin_n <= 1;
    waitlow(0);
    rd(REG_STATUS); chk("status master_clear_pin", 32'h2, rd_v[7:3]);
    end_of_test;
  end
endmodule
